// >>> hw/tebf_formatter.v
// event block formatter: turns triggers and channel hits into tagged words
// assumes trigger, hit and config inputs come from logic on clk, the
// slot pins from the backplane, and a reader that may stall out_ready
`timescale 1ns/1ps
`include "tebf_defines.vh"

module tebf_formatter #(
  parameter GEO_W = `TEBF_GEO_W,
  parameter NEVT_W = `TEBF_NEVT_W,
  parameter CHAN_W = `TEBF_CHAN_W,
  parameter HTIME_W = `TEBF_HTIME_W
)(
  input wire clk,
  input wire reset,
  input wire [GEO_W-1:0] geo_pin,
  input wire [NEVT_W-1:0] blk_events,
  input wire pad_to_four,
  input wire trig_valid,
  output wire trig_ready,
  input wire hit_valid,
  output wire hit_ready,
  input wire [CHAN_W-1:0] hit_chan,
  input wire [HTIME_W-1:0] hit_time,
  input wire hits_done,
  output wire hits_done_ready,
  input wire flush,
  output wire flush_ready,
  output wire [`TEBF_WORD_W-1:0] out_data,
  output wire out_valid,
  input wire out_ready,
  output wire block_open,
  output wire [`TEBF_STAMP_W-1:0] stamp
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_BHDR = 4'h1;
  localparam [3:0] S_EHDR = 4'h2;
  localparam [3:0] S_TIME1 = 4'h3;
  localparam [3:0] S_TIME2 = 4'h4;
  localparam [3:0] S_HITS = 4'h5;
  localparam [3:0] S_TRL = 4'h6;
  localparam [3:0] S_FILL = 4'h7;
  localparam [3:0] S_DNV = 4'h8;

  // builds a defining word; all defining words go through here
  function [`TEBF_WORD_W-1:0] mk_def;
    input [`TEBF_TAG_W-1:0] tag;
    input [`TEBF_PAY_W-1:0] pay;
    begin
      mk_def = {1'b1, tag, pay};
    end
  endfunction

  // builds a continuation word for the last defined type
  function [`TEBF_WORD_W-1:0] mk_cont;
    input [`TEBF_CONT_W-1:0] pay;
    begin
      mk_cont = {1'b0, pay};
    end
  endfunction

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [`TEBF_WORD_W-1:0] out_data_ff;
  reg [`TEBF_WORD_W-1:0] nxt_out_data;
  reg out_valid_ff;
  reg nxt_out_valid;
  reg [`TEBF_STAMP_W-1:0] stamp_ff;
  reg [`TEBF_STAMP_W-1:0] tstamp_ff;
  reg [`TEBF_STAMP_W-1:0] nxt_tstamp;
  reg [`TEBF_ACC_W-1:0] acc_ff;
  reg [`TEBF_ACC_W-1:0] nxt_acc;
  reg [`TEBF_BNUM_W-1:0] bnum_ff;
  reg [`TEBF_BNUM_W-1:0] nxt_bnum;
  reg [NEVT_W-1:0] evt_ff;
  reg [NEVT_W-1:0] nxt_evt;
  reg [NEVT_W-1:0] nevt_ff;
  reg [NEVT_W-1:0] nxt_nevt;
  reg [`TEBF_NWRD_W-1:0] wcnt_ff;
  reg [`TEBF_NWRD_W-1:0] nxt_wcnt;
  reg pad4_ff;
  reg nxt_pad4;
  reg [GEO_W-1:0] geo_s1_ff;
  reg [GEO_W-1:0] geo_ff;
  reg [GEO_W-1:0] geo_blk_ff;
  reg [GEO_W-1:0] nxt_geo_blk;

  wire can_emit;
  wire [NEVT_W-1:0] evt_inc;
  wire [1:0] pad_mask;
  wire [`TEBF_PAY_W-1:0] bhdr_pay;
  wire [`TEBF_PAY_W-1:0] btrl_pay;
  wire [`TEBF_PAY_W-1:0] hit_pay;
  wire [`TEBF_NWRD_W-1:0] wcnt_inc;

  // output slot frees when empty or when the reader takes the word
  assign can_emit = !out_valid_ff || out_ready;
  assign evt_inc = evt_ff + {{(NEVT_W-1){1'b0}}, 1'b1};
  assign wcnt_inc = wcnt_ff + {{(`TEBF_NWRD_W-1){1'b0}}, 1'b1};
  assign pad_mask = pad4_ff ? `TEBF_PAD4_MASK : `TEBF_PAD2_MASK;

  // slot latched per block so header and trailer always agree
  assign bhdr_pay = {geo_blk_ff, nevt_ff, bnum_ff};
  assign btrl_pay = {geo_blk_ff, wcnt_inc};
  assign hit_pay = {{(`TEBF_PAY_W-CHAN_W-HTIME_W-`TEBF_CHAN_LO+HTIME_W){1'b0}},
                    hit_chan, hit_time};

  // one event at a time; the next trigger waits for the window close
  assign trig_ready = (state_ff == S_IDLE);
  assign hit_ready = (state_ff == S_HITS) && can_emit;
  assign hits_done_ready = (state_ff == S_HITS) && !hit_valid;
  // refused inside a block so a not-valid word never splits one
  assign flush_ready = (state_ff == S_IDLE) && !trig_valid &&
                       (evt_ff == {NEVT_W{1'b0}});
  assign out_data = out_data_ff;
  assign out_valid = out_valid_ff;
  assign block_open = (evt_ff != {NEVT_W{1'b0}}) || (state_ff != S_IDLE);
  assign stamp = stamp_ff;

  // backplane slot pins are asynchronous; two stages before use
  always @(posedge clk)
  begin
    geo_s1_ff <= geo_pin;
    geo_ff <= geo_s1_ff;
  end

  // free-running timestamp; time zero is the release of reset
  always @(posedge clk)
  begin
    if (reset)
    begin
      stamp_ff <= `TEBF_STAMP_RST;
    end
    else
    begin
      stamp_ff <= stamp_ff + {{(`TEBF_STAMP_W-1){1'b0}}, 1'b1};
    end
  end

  always @*
  begin
    nxt_state = state_ff;
    nxt_out_data = out_data_ff;
    nxt_out_valid = out_valid_ff && !out_ready;
    nxt_tstamp = tstamp_ff;
    nxt_acc = acc_ff;
    nxt_bnum = bnum_ff;
    nxt_evt = evt_ff;
    nxt_nevt = nevt_ff;
    nxt_wcnt = wcnt_ff;
    nxt_pad4 = pad4_ff;
    nxt_geo_blk = geo_blk_ff;
    case (state_ff)
      S_IDLE:
      begin
        if (trig_valid)
        begin
          // time and number are frozen at acceptance, not at emission
          nxt_tstamp = stamp_ff;
          nxt_acc = acc_ff + {{(`TEBF_ACC_W-1){1'b0}}, 1'b1};
          if (evt_ff == {NEVT_W{1'b0}})
          begin
            // size fixed at block start so the header count is exact
            nxt_nevt = (blk_events == {NEVT_W{1'b0}}) ?
                       {{(NEVT_W-1){1'b0}}, 1'b1} : blk_events;
            nxt_pad4 = pad_to_four;
            nxt_geo_blk = geo_ff;
            nxt_state = S_BHDR;
          end
          else
          begin
            nxt_state = S_EHDR;
          end
        end
        else if (flush && evt_ff == {NEVT_W{1'b0}})
        begin
          nxt_state = S_DNV;
        end
      end
      S_BHDR:
      begin
        if (can_emit)
        begin
          nxt_out_data = mk_def(`TEBF_TAG_BLK_HDR, bhdr_pay);
          nxt_out_valid = 1'b1;
          nxt_wcnt = {{(`TEBF_NWRD_W-1){1'b0}}, 1'b1};
          nxt_state = S_EHDR;
        end
      end
      S_EHDR:
      begin
        if (can_emit)
        begin
          nxt_out_data = mk_def(`TEBF_TAG_EVT_HDR, acc_ff);
          nxt_out_valid = 1'b1;
          nxt_wcnt = wcnt_inc;
          nxt_state = S_TIME1;
        end
      end
      S_TIME1:
      begin
        if (can_emit)
        begin
          nxt_out_data = mk_def(`TEBF_TAG_TRIG_TIME,
            {3'h0, tstamp_ff[`TEBF_STAMP_W-1:`TEBF_HALF_W]});
          nxt_out_valid = 1'b1;
          nxt_wcnt = wcnt_inc;
          nxt_state = S_TIME2;
        end
      end
      S_TIME2:
      begin
        if (can_emit)
        begin
          nxt_out_data = mk_cont({7'h00,
            tstamp_ff[`TEBF_HALF_W-1:0]});
          nxt_out_valid = 1'b1;
          nxt_wcnt = wcnt_inc;
          nxt_state = S_HITS;
        end
      end
      S_HITS:
      begin
        // a pending hit always goes out before the window close
        if (hit_valid)
        begin
          if (can_emit)
          begin
            nxt_out_data = mk_def(`TEBF_TAG_HIT, hit_pay);
            nxt_out_valid = 1'b1;
            nxt_wcnt = wcnt_inc;
          end
        end
        else if (hits_done)
        begin
          nxt_evt = evt_inc;
          nxt_state = (evt_inc == nevt_ff) ? S_TRL : S_IDLE;
        end
      end
      S_TRL:
      begin
        if (can_emit)
        begin
          nxt_out_data = mk_def(`TEBF_TAG_BLK_TRL, btrl_pay);
          nxt_out_valid = 1'b1;
          nxt_wcnt = wcnt_inc;
          nxt_evt = {NEVT_W{1'b0}};
          // block number wraps; readers align on the low bits only
          nxt_bnum = bnum_ff + {{(`TEBF_BNUM_W-1){1'b0}}, 1'b1};
          nxt_state = S_FILL;
        end
      end
      S_FILL:
      begin
        // word count keeps running here only to steer the padding
        if ((wcnt_ff[1:0] & pad_mask) == 2'h0)
        begin
          nxt_state = S_IDLE;
        end
        else if (can_emit)
        begin
          nxt_out_data = mk_def(`TEBF_TAG_FILLER,
                                {`TEBF_PAY_W{1'b0}});
          nxt_out_valid = 1'b1;
          nxt_wcnt = wcnt_inc;
        end
      end
      S_DNV:
      begin
        // stands alone, outside any block and any tally
        if (can_emit)
        begin
          nxt_out_data = mk_def(`TEBF_TAG_NOT_VALID,
                                {`TEBF_PAY_W{1'b0}});
          nxt_out_valid = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default:
      begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= S_IDLE;
      out_data_ff <= {`TEBF_WORD_W{1'b0}};
      out_valid_ff <= 1'b0;
      tstamp_ff <= `TEBF_STAMP_RST;
      acc_ff <= `TEBF_ACC_RST;
      bnum_ff <= `TEBF_BNUM_RST;
      evt_ff <= {NEVT_W{1'b0}};
      nevt_ff <= {{(NEVT_W-1){1'b0}}, 1'b1};
      wcnt_ff <= {`TEBF_NWRD_W{1'b0}};
      pad4_ff <= 1'b0;
      geo_blk_ff <= {GEO_W{1'b0}};
    end
    else
    begin
      state_ff <= nxt_state;
      out_data_ff <= nxt_out_data;
      out_valid_ff <= nxt_out_valid;
      tstamp_ff <= nxt_tstamp;
      acc_ff <= nxt_acc;
      bnum_ff <= nxt_bnum;
      evt_ff <= nxt_evt;
      nevt_ff <= nxt_nevt;
      wcnt_ff <= nxt_wcnt;
      pad4_ff <= nxt_pad4;
      geo_blk_ff <= nxt_geo_blk;
    end
  end

endmodule

// >>> pkg/tebf_defines.vh
// constants for the event block formatter: tags, field positions, resets
// assumes inclusion by bare name from the formatter design file
`ifndef TEBF_DEFINES_VH
`define TEBF_DEFINES_VH

`define TEBF_WORD_W 32
`define TEBF_DEF_BIT 31
`define TEBF_TAG_LO 27
`define TEBF_TAG_W 4
`define TEBF_PAY_W 27
`define TEBF_CONT_W 31

`define TEBF_TAG_BLK_HDR 4'h0
`define TEBF_TAG_BLK_TRL 4'h1
`define TEBF_TAG_EVT_HDR 4'h2
`define TEBF_TAG_TRIG_TIME 4'h3
`define TEBF_TAG_HIT 4'h8
`define TEBF_TAG_NOT_VALID 4'he
`define TEBF_TAG_FILLER 4'hf

`define TEBF_GEO_LO 22
`define TEBF_GEO_W 5
`define TEBF_NEVT_LO 10
`define TEBF_NEVT_W 12
`define TEBF_BNUM_LO 0
`define TEBF_BNUM_W 10
`define TEBF_NWRD_LO 0
`define TEBF_NWRD_W 22
`define TEBF_ACC_W 27

`define TEBF_STAMP_W 48
`define TEBF_HALF_W 24
`define TEBF_CHAN_LO 16
`define TEBF_CHAN_W 7
`define TEBF_HTIME_LO 0
`define TEBF_HTIME_W 16

`define TEBF_STAMP_RST 48'h000000000000
`define TEBF_ACC_RST 27'h0000000
`define TEBF_BNUM_RST 10'h000
`define TEBF_PAD2_MASK 2'h1
`define TEBF_PAD4_MASK 2'h3

`endif

// >>> testbench/tebf_properties.sv
// timing checks on the formatter ports
// assumes a bind onto tebf_formatter, all on clk
`timescale 1ns/1ps
module tebf_properties #(
  parameter CHAN_W = 7,
  parameter HTIME_W = 16
)(
  input wire clk,
  input wire reset,
  input wire trig_valid,
  input wire trig_ready,
  input wire hit_valid,
  input wire hit_ready,
  input wire [CHAN_W-1:0] hit_chan,
  input wire [HTIME_W-1:0] hit_time,
  input wire [31:0] out_data,
  input wire out_valid,
  input wire out_ready,
  input wire [47:0] stamp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire [3:0] tag = out_data[30:27];
  sequence s_hdr_take;
    out_valid && out_ready && out_data[31:27] == 5'h12;
  endsequence
  sequence s_t1;
    out_valid && out_data[31:24] == 8'h98;
  endsequence
  sequence s_t1_take;
    out_valid && out_ready && out_data[31:24] == 8'h98;
  endsequence
  sequence s_t2;
    out_valid && out_data[31:24] == 8'h00;
  endsequence
  a_stamp_start: assert property (
    $past(reset) |-> stamp == 48'h0 ##1 stamp == 48'h1)
    else $error("timestamp did not start from zero");
  a_stamp_count: assert property (
    !$past(reset) |-> stamp == $past(stamp) + 48'h1)
    else $error("timestamp did not advance");
  a_no_reserved: assert property (
    out_valid && out_data[31] |-> !(tag inside {[4:7], [9:13]}))
    else $error("reserved tag emitted");
  a_word_holds: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("word changed before taken");
  a_time_upper: assert property (
    s_hdr_take |=> s_t1)
    else $error("first time word missing");
  a_time_lower: assert property (
    s_t1_take |=> s_t2)
    else $error("second time word missing");
  a_trig_first: assert property (
    trig_valid && trig_ready && !out_valid |=> ##1
      out_valid && out_data[31] && (tag == 4'h0 || tag == 4'h2))
    else $error("wrong first word after trigger");
  a_trig_busy: assert property (
    trig_valid && trig_ready |=> !trig_ready)
    else $error("second trigger accepted in event");
  a_hit_word: assert property (
    hit_valid && hit_ready |=> out_valid &&
      out_data == {5'h18, 4'h0, $past(hit_chan), $past(hit_time)})
    else $error("hit word wrong");
endmodule

// >>> testbench/tebf_reader.sv
// reader model: takes formatter words into a queue, may stall
// assumes out_valid and out_data come from the formatter on clk
`timescale 1ns/1ps
module tebf_reader (
  input wire clk,
  input wire reset,
  input wire [31:0] out_data,
  input wire out_valid,
  input wire slow,
  output logic out_ready = 1'b0
);
  logic [31:0] q[$];
  logic [1:0] ph_ff;
  always @(posedge clk)
  begin
    if (reset)
    begin
      ph_ff <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      ph_ff <= ph_ff + 2'h1;
      // one word in four when slow, so the formatter must hold words
      out_ready <= !slow || ph_ff == 2'h3;
      if (out_valid && out_ready)
        q.push_back(out_data);
    end
  end
endmodule

// >>> testbench/testbench.sv
// self-checking bench for the event block formatter
// assumes the reader model and the properties checker
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] geo_pin = 5'h0b;
  logic [11:0] blk_events = 12'h002;
  logic pad_to_four = 1'b1;
  logic trig_valid = 1'b0;
  logic hit_valid = 1'b0;
  logic [6:0] hit_chan = 7'h00;
  logic [15:0] hit_time = 16'h0000;
  logic hits_done = 1'b0;
  logic flush = 1'b0;
  logic slow = 1'b1;
  wire trig_ready, hit_ready, hits_done_ready, flush_ready;
  wire [31:0] out_data;
  wire out_valid, out_ready, block_open;
  wire [47:0] stamp;
  logic [47:0] cyc = 48'h0;
  logic [26:0] acc = 27'h0;
  logic [31:0] exp_q[$];
  int errors = 0;
  int n_checks = 0;
  int ticks = 0;
  always #5 clk = !clk;
  tebf_formatter dut (.clk, .reset, .geo_pin, .blk_events, .pad_to_four,
    .trig_valid, .trig_ready, .hit_valid, .hit_ready, .hit_chan, .hit_time,
    .hits_done, .hits_done_ready, .flush, .flush_ready, .out_data,
    .out_valid, .out_ready, .block_open, .stamp);
  tebf_reader rd (.clk, .reset, .out_data, .out_valid, .slow, .out_ready);
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= reset ? 48'h0 : cyc + 48'h1;
    ticks <= ticks + 1;
    if (ticks == 20000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task automatic check(input string nm, input logic [47:0] seen,
    input logic [47:0] want);
    n_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, want, seen);
    end
  endtask
  function automatic logic rdy(input int w);
    case (w)
      0: return trig_ready;
      1: return hit_ready;
      2: return hits_done_ready;
      default: return flush_ready;
    endcase
  endfunction
  task automatic hs(input int w);
    do @(negedge clk); while (rdy(w) !== 1'b1);
  endtask
  task automatic one_event(input int nh);
    logic [47:0] ts;
    @(posedge clk) trig_valid <= 1'b1;
    hs(0);
    ts = cyc;
    acc++;
    exp_q.push_back({5'h12, acc});
    exp_q.push_back({8'h98, ts[47:24]});
    exp_q.push_back({8'h00, ts[23:0]});
    @(posedge clk) trig_valid <= 1'b0;
    for (int i = 0; i < nh; i++)
    begin
      hit_valid <= 1'b1;
      hit_chan <= 7'h5f - 7'(i * 95);
      hit_time <= 16'hfff0 + 16'(i);
      hs(1);
      check("done_rdy", hits_done_ready, 1'b0);
      check("open", block_open, 1'b1);
      check("flush_rdy", flush_ready, 1'b0);
      exp_q.push_back({5'h18, 4'h0, hit_chan, hit_time});
      @(posedge clk);
    end
    hit_valid <= 1'b0;
    hits_done <= 1'b1;
    hs(2);
    @(posedge clk) hits_done <= 1'b0;
  endtask
  task automatic run_blk(input int ne, input int nh, input int pad,
    input logic [9:0] bnum, input int cfg);
    @(posedge clk);
    // cfg 0 stands for a one-event block
    blk_events <= 12'(cfg);
    pad_to_four <= pad == 4;
    slow <= pad == 4;
    exp_q.push_back({5'h10, geo_pin, 12'(ne), bnum});
    for (int e = 0; e < ne; e++)
      one_event(e ? 0 : nh);
    exp_q.push_back({5'h11, geo_pin, 22'(exp_q.size() + 1)});
    while (exp_q.size() % pad)
      exp_q.push_back(32'hf8000000);
    do @(negedge clk); while (block_open !== 1'b0 || out_valid !== 1'b0);
    check("count", 48'(rd.q.size()), 48'(exp_q.size()));
    foreach (exp_q[i])
      check("word", rd.q[i], exp_q[i]);
    rd.q.delete();
    exp_q.delete();
  endtask
  task automatic t_flush;
    @(posedge clk) flush <= 1'b1;
    hs(3);
    @(posedge clk) flush <= 1'b0;
    do @(negedge clk); while (rd.q.size() == 0);
    check("empty", rd.q[0], 32'hf0000000);
    rd.q.delete();
  endtask
  task automatic t_reset;
    repeat (15) @(posedge clk);
    @(negedge clk);
    check("stamp", stamp, 48'h0);
    check("valid", out_valid, 1'b0);
    @(posedge clk) reset <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("stamp", stamp, cyc);
  endtask
  initial
  begin
    t_reset();
    run_blk(2, 2, 4, 10'h000, 2);
    run_blk(1, 0, 2, 10'h001, 1);
    run_blk(1, 1, 2, 10'h002, 0);
    t_flush();
    results();
  end
endmodule
bind tebf_formatter tebf_properties #(.CHAN_W(CHAN_W), .HTIME_W(HTIME_W))
  u_prop (.clk, .reset, .trig_valid, .trig_ready, .hit_valid, .hit_ready,
  .hit_chan, .hit_time, .out_data, .out_valid, .out_ready, .stamp);
